/* File: pkg/sas_pkg.sv */
// shared constants for the attribute autosave command block
package sas_pkg;
    // taskfile values
    localparam logic [7:0] CMD_SMART = 8'hB0;
    localparam logic [7:0] FEAT_READ_ATTR = 8'hD0;
    localparam logic [7:0] FEAT_AUTOSAVE = 8'hD2;
    localparam logic [7:0] CYL_LO_KEY = 8'h4F;
    localparam logic [7:0] CYL_HI_KEY = 8'hC2;
    localparam logic [7:0] SC_ENABLE = 8'hF1;
    localparam logic [7:0] SC_DISABLE = 8'h00;
    localparam logic [7:0] STATUS_OK = 8'h50;
    localparam logic [7:0] STATUS_ABORT = 8'h51;
    localparam logic [7:0] DEV_HEAD_OUT = 8'hE0;
    localparam logic [7:0] STATUS_RESET = 8'h50;
    // attribute sector layout
    localparam logic [9:0] SECTOR_BYTES = 10'h200;
    localparam logic [9:0] TABLE_START = 10'h002;
    localparam logic [9:0] ENTRY_BYTES = 10'h00C;
    localparam logic [3:0] POS_ID = 4'h0;
    localparam logic [3:0] POS_FLAG = 4'h1;
    localparam logic [3:0] POS_VALUE = 4'h3;
    localparam logic [3:0] POS_WORST = 4'h4;
    localparam logic [3:0] POS_RAW0 = 4'h5;
    localparam logic [9:0] TEMP_RAW_IDX = 10'h007;
    localparam logic [7:0] ID_TEMP = 8'hC2;
    localparam logic [7:0] ID_BAD_BLOCK = 8'hAA;
    localparam logic [7:0] ID_LIFE = 8'hE7;
    localparam logic [7:0] FLAG_TEMP = 8'h23;
    localparam logic [7:0] FLAG_BAD_BLOCK = 8'h03;
    localparam logic [7:0] FLAG_LIFE = 8'h13;
    // percentage scaling
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] PCT_MIN = 8'h01;
    localparam logic [15:0] ERASE_MAX_SLC = 16'hEA60;
    localparam logic [15:0] ERASE_MAX_MLC = 16'h0BB8;
    // command start latency during an autosave
    localparam int CLK_HZ = 40_000_000;
    localparam int CMD_START_MAX_S = 2;
    localparam int CMD_START_MAX_CYC = CMD_START_MAX_S * CLK_HZ;
endpackage

/* File: pkg/sas_div_if.sv */
// request and answer wires between the command block and its divider
`timescale 1ns/1ps
interface sas_div_if;
    logic start;
    logic [23:0] num;
    logic [15:0] den;
    logic busy;
    logic [23:0] quo;
    modport master (output start, output num, output den,
                    input busy, input quo);
    modport slave (input start, input num, input den,
                   output busy, output quo);
endinterface

/* File: logic/sas_divider.sv */
// sequential restoring divider, one quotient bit per cycle
`timescale 1ns/1ps
module sas_divider #(
    parameter int NW = 24
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // divide request
    sas_div_if.slave div
);
    logic [NW-1:0] quo_reg;
    logic [NW-1:0] num_reg;
    logic [16:0] rem_reg;
    logic [15:0] den_reg;
    logic [4:0] cnt_reg;
    logic busy_reg;
    logic [16:0] shifted;
    logic [16:0] trial;
    logic fits;

    assign shifted = {rem_reg[15:0], num_reg[NW-1]};
    assign trial = shifted - {1'b0, den_reg};
    assign fits = shifted >= {1'b0, den_reg};
    assign div.busy = busy_reg;
    assign div.quo = quo_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            busy_reg <= 1'b0;
            cnt_reg <= 5'h00;
            quo_reg <= '0;
            num_reg <= '0;
            rem_reg <= '0;
            den_reg <= '0;
        end else if (div.start && !busy_reg) begin
            busy_reg <= 1'b1;
            cnt_reg <= 5'(NW);
            num_reg <= div.num;
            den_reg <= div.den;
            rem_reg <= '0;
        end else if (busy_reg) begin
            rem_reg <= fits ? trial : shifted;
            num_reg <= {num_reg[NW-2:0], 1'b0};
            quo_reg <= {quo_reg[NW-2:0], fits};
            cnt_reg <= cnt_reg - 5'h01;
            busy_reg <= cnt_reg != 5'h01;
        end
    end
endmodule // sas_divider

/* File: logic/sas_autosave.sv */
`timescale 1ns/1ps
module sas_autosave #(
    parameter int WAIT_LIMIT = sas_pkg::CMD_START_MAX_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // taskfile command
    input wire logic cmd_valid_i,
    output logic cmd_ready_o,
    input wire logic [7:0] feature_i,
    input wire logic [7:0] sect_cnt_i,
    input wire logic [7:0] cyl_lo_i,
    input wire logic [7:0] cyl_hi_i,
    input wire logic [7:0] command_i,
    // completion
    output logic done_o,
    output logic [7:0] status_o,
    output logic [7:0] dev_head_o,
    // data-in sector
    output logic data_valid_o,
    input wire logic data_ready_i,
    output logic [7:0] data_o,
    // attribute sources
    input wire logic [7:0] temp_raw_i,
    input wire logic [15:0] bb_max_i,
    input wire logic [15:0] bb_cur_i,
    input wire logic [15:0] erase_avg_i,
    input wire logic mlc_i,
    // nonvolatile store
    input wire logic nv_flag_i,
    input wire logic save_trig_i,
    input wire logic power_event_i,
    output logic nv_req_o,
    output logic nv_kind_flag_o,
    output logic nv_flag_o,
    input wire logic nv_ack_i,
    output logic nv_abort_o,
    output logic autosave_en_o
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_DIV_BB, ST_DIV_LIFE, ST_SEND, ST_NV_WAIT, ST_NV_WRITE
    } sas_state_t;

    sas_state_t state_reg;
    sas_div_if div_bus ();
    logic en_reg, loaded_reg, save_reg, done_reg, err_reg, valid_reg;
    logic [7:0] status_reg, dev_head_reg, data_reg, temp_reg;
    logic [7:0] bb_pct_reg, life_pct_reg;
    logic [15:0] bb_max_reg, bb_cur_reg, erase_avg_reg;
    logic mlc_reg, div_go_reg, div_wait_reg;
    logic [9:0] idx_reg;
    logic [31:0] wait_cnt_reg;

    sas_divider #(.NW(24)) u_div (
        .ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i),
        .div(div_bus)
    );

    logic keys_ok, is_autosave, is_read, accept, div_done;
    assign keys_ok = command_i == sas_pkg::CMD_SMART &&
                     cyl_lo_i == sas_pkg::CYL_LO_KEY &&
                     cyl_hi_i == sas_pkg::CYL_HI_KEY;
    assign is_autosave = keys_ok && feature_i == sas_pkg::FEAT_AUTOSAVE;
    assign is_read = keys_ok && feature_i == sas_pkg::FEAT_READ_ATTR;
    // commands wait for the stored setting to load after reset
    assign cmd_ready_o = state_reg == ST_IDLE && loaded_reg;
    assign accept = cmd_valid_i && cmd_ready_o;
    assign div_done = div_wait_reg && !div_go_reg && !div_bus.busy;

    logic [15:0] bb_diff, erase_max;
    logic bb_zero;
    assign bb_diff = bb_max_reg - bb_cur_reg;
    assign bb_zero = bb_max_reg == 16'h0000 || bb_cur_reg >= bb_max_reg;
    assign erase_max = mlc_reg ? sas_pkg::ERASE_MAX_MLC
                               : sas_pkg::ERASE_MAX_SLC;
    assign div_bus.start = div_go_reg;
    assign div_bus.num = state_reg == ST_DIV_BB ?
        24'(bb_diff) * 24'(sas_pkg::PCT_FULL) :
        24'(erase_avg_reg) * 24'(sas_pkg::PCT_FULL);
    assign div_bus.den = state_reg == ST_DIV_BB ? bb_max_reg : erase_max;

    logic [7:0] bb_res, life_res;
    assign bb_res = bb_zero || div_bus.quo == 24'h00_0000 ? sas_pkg::PCT_MIN
        : div_bus.quo > 24'(sas_pkg::PCT_FULL) ? sas_pkg::PCT_FULL
        : div_bus.quo[7:0];
    assign life_res = div_bus.quo >= 24'(sas_pkg::PCT_FULL) ? 8'h00
        : sas_pkg::PCT_FULL - div_bus.quo[7:0];

    // sector byte selection from the next index
    logic [9:0] idx_next, rel;
    logic [1:0] ent;
    logic [3:0] pos;
    logic in_tab, last_byte, beat;
    logic [7:0] ent_id, ent_flag, ent_val, ent_raw, byte_next;
    assign beat = valid_reg && data_ready_i;
    assign last_byte = idx_reg == sas_pkg::SECTOR_BYTES - 10'h001;
    assign idx_next = state_reg == ST_SEND ? idx_reg + 10'h001 : 10'h000;
    assign rel = idx_next - sas_pkg::TABLE_START;
    assign in_tab = idx_next >= sas_pkg::TABLE_START &&
                    rel < 10'(3) * sas_pkg::ENTRY_BYTES;
    assign ent = rel < sas_pkg::ENTRY_BYTES ? 2'd0 :
                 rel < 10'(2) * sas_pkg::ENTRY_BYTES ? 2'd1 : 2'd2;
    assign pos = 4'(rel - 10'(ent) * sas_pkg::ENTRY_BYTES);
    assign ent_id = ent == 2'd0 ? sas_pkg::ID_TEMP :
                    ent == 2'd1 ? sas_pkg::ID_BAD_BLOCK : sas_pkg::ID_LIFE;
    assign ent_flag = ent == 2'd0 ? sas_pkg::FLAG_TEMP :
                      ent == 2'd1 ? sas_pkg::FLAG_BAD_BLOCK
                                  : sas_pkg::FLAG_LIFE;
    // temperature raw passes as signed two's complement
    assign ent_raw = ent == 2'd0 ? temp_reg :
                     ent == 2'd1 ? 8'h00 : life_pct_reg;
    assign ent_val = ent == 2'd0 ? sas_pkg::PCT_FULL - temp_reg :
                     ent == 2'd1 ? bb_pct_reg : life_pct_reg;
    assign byte_next = !in_tab ? 8'h00 :
                       pos == sas_pkg::POS_ID ? ent_id :
                       pos == sas_pkg::POS_FLAG ? ent_flag :
                       pos == sas_pkg::POS_VALUE ? ent_val :
                       pos == sas_pkg::POS_WORST ? ent_val :
                       pos == sas_pkg::POS_RAW0 ? ent_raw : 8'h00;

    // setting loaded from the store once after reset
    logic en_next;
    assign en_next = !accept || !is_autosave ? en_reg :
                     sect_cnt_i == sas_pkg::SC_ENABLE ? 1'b1 :
                     sect_cnt_i == sas_pkg::SC_DISABLE ? 1'b0 : en_reg;
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            loaded_reg <= 1'b0;
            en_reg <= 1'b0;
        end else if (!loaded_reg) begin
            loaded_reg <= 1'b1;
            en_reg <= nv_flag_i;
        end else begin
            // count selects on, off, or unchanged
            en_reg <= en_next;
        end
    end

    // background save; set wins over the ack clear
    logic save_set, wait_hit;
    assign save_set = (en_reg && save_trig_i) || power_event_i;
    assign wait_hit = state_reg == ST_NV_WAIT && save_reg &&
                      wait_cnt_reg >= 32'(WAIT_LIMIT - 2);
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            save_reg <= 1'b0;
        end else if (save_set && loaded_reg && state_reg != ST_NV_WRITE) begin
            save_reg <= 1'b1;
        end else if ((save_reg && nv_ack_i) || wait_hit) begin
            save_reg <= 1'b0;
        end
    end
    // give up the save before the start limit
    assign nv_abort_o = wait_hit;
    assign nv_req_o = save_reg || state_reg == ST_NV_WRITE;
    assign nv_kind_flag_o = state_reg == ST_NV_WRITE;
    assign nv_flag_o = en_reg;
    assign autosave_en_o = en_reg;

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            state_reg <= ST_IDLE;
            done_reg <= 1'b0;
            err_reg <= 1'b0;
            valid_reg <= 1'b0;
            status_reg <= sas_pkg::STATUS_RESET;
            dev_head_reg <= sas_pkg::DEV_HEAD_OUT;
            data_reg <= 8'h00;
            idx_reg <= 10'h000;
            temp_reg <= 8'h00;
            bb_pct_reg <= 8'h00;
            life_pct_reg <= 8'h00;
            bb_max_reg <= 16'h0000;
            bb_cur_reg <= 16'h0000;
            erase_avg_reg <= 16'h0000;
            mlc_reg <= 1'b0;
            div_go_reg <= 1'b0;
            div_wait_reg <= 1'b0;
            wait_cnt_reg <= 32'h0000_0000;
        end else begin
            done_reg <= 1'b0;
            div_go_reg <= 1'b0;
            case (state_reg)
                ST_IDLE: begin
                    if (accept && is_autosave) begin
                        state_reg <= ST_NV_WAIT;
                        wait_cnt_reg <= 32'h0000_0000;
                    end else if (accept && is_read) begin
                        temp_reg <= temp_raw_i;
                        bb_max_reg <= bb_max_i;
                        bb_cur_reg <= bb_cur_i;
                        erase_avg_reg <= erase_avg_i;
                        mlc_reg <= mlc_i;
                        div_go_reg <= 1'b1;
                        div_wait_reg <= 1'b1;
                        state_reg <= ST_DIV_BB;
                    end else if (accept) begin
                        // unsupported commands abort without data
                        done_reg <= 1'b1;
                        err_reg <= 1'b1;
                        status_reg <= sas_pkg::STATUS_ABORT;
                    end
                end
                ST_DIV_BB: begin
                    if (div_done) begin
                        bb_pct_reg <= bb_res;
                        div_go_reg <= 1'b1;
                        state_reg <= ST_DIV_LIFE;
                    end
                end
                ST_DIV_LIFE: begin
                    if (div_done) begin
                        life_pct_reg <= life_res;
                        div_wait_reg <= 1'b0;
                        data_reg <= byte_next;
                        idx_reg <= 10'h000;
                        valid_reg <= 1'b1;
                        state_reg <= ST_SEND;
                    end
                end
                ST_SEND: begin
                    if (beat && last_byte) begin
                        valid_reg <= 1'b0;
                        done_reg <= 1'b1;
                        err_reg <= 1'b0;
                        status_reg <= sas_pkg::STATUS_OK;
                        dev_head_reg <= sas_pkg::DEV_HEAD_OUT;
                        state_reg <= ST_IDLE;
                    end else if (beat) begin
                        idx_reg <= idx_next;
                        data_reg <= byte_next;
                    end
                end
                ST_NV_WAIT: begin
                    wait_cnt_reg <= wait_cnt_reg + 32'h0000_0001;
                    if (!save_reg) begin
                        state_reg <= ST_NV_WRITE;
                    end
                end
                default: begin
                    // setting stored, then status without data
                    if (nv_ack_i) begin
                        done_reg <= 1'b1;
                        err_reg <= 1'b0;
                        status_reg <= sas_pkg::STATUS_OK;
                        dev_head_reg <= sas_pkg::DEV_HEAD_OUT;
                        state_reg <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    assign done_o = done_reg;
    assign status_o = status_reg;
    assign dev_head_o = dev_head_reg;
    assign data_valid_o = valid_reg;
    assign data_o = data_reg;

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    chk_temp_raw_byte: assert property (
        valid_reg && idx_reg == sas_pkg::TEMP_RAW_IDX |-> data_o == temp_reg)
        else $error("temperature raw byte wrong");
    chk_bb_clamp_range: assert property (
        state_reg == ST_SEND |-> bb_pct_reg >= 8'h01 && bb_pct_reg <= 8'h64)
        else $error("bad block value out of range");
    chk_bb_full_margin: assert property (
        state_reg == ST_SEND && bb_cur_reg == 16'h0000 &&
        bb_max_reg != 16'h0000 |-> bb_pct_reg == 8'h64)
        else $error("bad block value not full");
    chk_life_zero_wear: assert property (
        state_reg == ST_SEND && erase_avg_reg == 16'h0000
        |-> life_pct_reg == 8'h64)
        else $error("life value not full at zero wear");
    chk_enable_on: assert property (
        accept && is_autosave && sect_cnt_i == 8'hF1 |=> en_reg)
        else $error("autosave not enabled");
    chk_enable_off: assert property (
        accept && is_autosave && sect_cnt_i == 8'h00 |=> !en_reg)
        else $error("autosave not disabled");
    chk_vendor_keep: assert property (
        accept && is_autosave && sect_cnt_i != 8'h00 && sect_cnt_i != 8'hF1
        |=> $stable(en_reg))
        else $error("setting changed by other count");
    chk_setting_stored: assert property (
        $past(loaded_reg) && $changed(en_reg) |-> state_reg == ST_NV_WAIT)
        else $error("changed setting not headed for store");
    chk_save_cause: assert property (
        $rose(save_reg) |-> $past(save_set))
        else $error("save started without cause");
    chk_start_bound: assert property (
        state_reg == ST_NV_WAIT |-> wait_cnt_reg < 32'(WAIT_LIMIT))
        else $error("command start delayed too long");
    chk_one_sector: assert property (
        beat && last_byte |=> done_o && !data_valid_o && idx_reg == 10'h1FF)
        else $error("sector length wrong");
    chk_status_ok: assert property (
        done_o && !err_reg |-> status_o == 8'h50 && dev_head_o == 8'hE0)
        else $error("completion status wrong");
    chk_no_data_nv: assert property (
        state_reg == ST_NV_WAIT || state_reg == ST_NV_WRITE |-> !data_valid_o)
        else $error("data during non-data command");
    cov_enable: cover property (accept && is_autosave && sect_cnt_i == 8'hF1);
    cov_disable: cover property (accept && is_autosave && sect_cnt_i == 8'h00);
    cov_read_done: cover property (beat && last_byte);
    cov_save_abort: cover property (wait_hit);
endmodule // sas_autosave

/* File: bench/sas_host_model.sv */
// host-side model: issues taskfile commands, sinks data-in bytes
`timescale 1ns/1ps
module sas_host_model (
    // clock
    input wire logic ref_clk_i,
    // taskfile command
    output logic cmd_valid_o,
    input wire logic cmd_ready_i,
    output logic [7:0] feature_o,
    output logic [7:0] sect_cnt_o,
    output logic [7:0] cyl_lo_o,
    output logic [7:0] cyl_hi_o,
    output logic [7:0] command_o,
    // completion and data-in
    input wire logic done_i,
    input wire logic data_valid_i,
    input wire logic [7:0] data_i,
    output logic data_ready_o
);
    logic [7:0] mem [0:511];
    int nbytes = 0;
    int beat = 0;
    initial begin
        cmd_valid_o = 1'b0;
        {feature_o, sect_cnt_o, cyl_lo_o, cyl_hi_o, command_o} = '0;
        data_ready_o = 1'b0;
    end
    // stalls one cycle in three, like a busy host
    always @(negedge ref_clk_i) begin
        beat <= beat + 1;
        data_ready_o <= (beat % 3) != 2;
    end
    always @(posedge ref_clk_i) begin
        if (data_valid_i && data_ready_o) begin
            if (nbytes < 512)
                mem[nbytes] <= data_i;
            nbytes <= nbytes + 1;
        end
    end
    function automatic int temp_c(input logic [7:0] raw);
        return (raw > 8'd127) ? int'(raw) - 256 : int'(raw);
    endfunction
    task automatic issue(input logic [7:0] feat, input logic [7:0] sc,
                         input logic [7:0] cmd, output int lat);
        int n;
        n = 0;
        nbytes = 0;
        @(negedge ref_clk_i);
        feature_o = feat;
        sect_cnt_o = sc;
        cyl_lo_o = sas_pkg::CYL_LO_KEY;
        cyl_hi_o = sas_pkg::CYL_HI_KEY;
        command_o = cmd;
        cmd_valid_o = 1'b1;
        do @(posedge ref_clk_i); while (cmd_ready_i !== 1'b1);
        @(negedge ref_clk_i);
        cmd_valid_o = 1'b0;
        // released fields must not look still valid
        {feature_o, sect_cnt_o, cyl_lo_o, cyl_hi_o, command_o} =
            ~{feature_o, sect_cnt_o, cyl_lo_o, cyl_hi_o, command_o};
        while (done_i !== 1'b1 && n < 4000) begin
            @(negedge ref_clk_i);
            n++;
        end
        lat = n;
    endtask
endmodule // sas_host_model

/* File: bench/smart_attribute_autosave_tb.sv */
// self-checking bench for the attribute autosave command block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
    fails++; $display("unexpected %s exp %h got %h", nm, e, g); end end
module smart_attribute_autosave_tb;
    localparam int WL = 20;
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] temp_raw_i = 8'h00;
    logic [15:0] bb_max_i = 16'h0001, bb_cur_i = 16'h0000;
    logic [15:0] erase_avg_i = 16'h0000;
    logic mlc_i = 1'b0, save_trig_i = 1'b0, power_event_i = 1'b0;
    logic nv_ack_i = 1'b0, nv_store = 1'b0, nv_hold = 1'b0;
    logic cmd_valid_i, cmd_ready_o, done_o, data_valid_o, data_ready_i;
    logic [7:0] feature_i, sect_cnt_i, cyl_lo_i, cyl_hi_i, command_i;
    logic [7:0] status_o, dev_head_o, data_o;
    logic nv_req_o, nv_kind_flag_o, nv_flag_o, nv_abort_o, autosave_en_o;
    int fails = 0, num_checks = 0, nv_wait = 0, saves = 0, aborts = 0;
    int lat;
    always #12.5 ref_clk_i = ~ref_clk_i;
    sas_autosave #(.WAIT_LIMIT(WL)) dut (.ref_clk_i(ref_clk_i),
        .nrst_i(nrst_i), .cmd_valid_i(cmd_valid_i),
        .cmd_ready_o(cmd_ready_o), .feature_i(feature_i),
        .sect_cnt_i(sect_cnt_i), .cyl_lo_i(cyl_lo_i), .cyl_hi_i(cyl_hi_i),
        .command_i(command_i), .done_o(done_o), .status_o(status_o),
        .dev_head_o(dev_head_o), .data_valid_o(data_valid_o),
        .data_ready_i(data_ready_i), .data_o(data_o),
        .temp_raw_i(temp_raw_i), .bb_max_i(bb_max_i), .bb_cur_i(bb_cur_i),
        .erase_avg_i(erase_avg_i), .mlc_i(mlc_i), .nv_flag_i(nv_store),
        .save_trig_i(save_trig_i), .power_event_i(power_event_i),
        .nv_req_o(nv_req_o), .nv_kind_flag_o(nv_kind_flag_o),
        .nv_flag_o(nv_flag_o), .nv_ack_i(nv_ack_i), .nv_abort_o(nv_abort_o),
        .autosave_en_o(autosave_en_o));
    sas_host_model h (.ref_clk_i(ref_clk_i), .cmd_valid_o(cmd_valid_i),
        .cmd_ready_i(cmd_ready_o), .feature_o(feature_i),
        .sect_cnt_o(sect_cnt_i), .cyl_lo_o(cyl_lo_i), .cyl_hi_o(cyl_hi_i),
        .command_o(command_i), .done_i(done_o), .data_valid_i(data_valid_o),
        .data_i(data_o), .data_ready_o(data_ready_i));
    // nonvolatile store: acks after three cycles unless held
    always @(negedge ref_clk_i) begin
        nv_ack_i <= 1'b0;
        nv_wait <= 0;
        if (nv_req_o && !nv_ack_i && !nv_hold) begin
            nv_wait <= nv_wait + 1;
            if (nv_wait == 2) begin
                nv_ack_i <= 1'b1;
                nv_wait <= 0;
                if (nv_kind_flag_o)
                    nv_store <= nv_flag_o;
                else
                    saves <= saves + 1;
            end
        end
    end
    // an abandoned save frees the store again
    always @(posedge ref_clk_i) begin
        if (nv_abort_o === 1'b1) begin
            aborts <= aborts + 1;
            nv_hold <= 1'b0;
        end
    end
    task automatic end_test(input string nm);
        $display("test %s finished", nm);
    endtask
    task automatic do_reset();
        @(negedge ref_clk_i);
        nrst_i = 1'b0;
        repeat (8) @(negedge ref_clk_i);
        `CHK("ready in reset", 1'b0, cmd_ready_o)
        nrst_i = 1'b1;
        repeat (3) @(negedge ref_clk_i);
    endtask
    task automatic pulse_trig(input logic pwr);
        @(negedge ref_clk_i);
        if (pwr) power_event_i = 1'b1;
        else save_trig_i = 1'b1;
        @(negedge ref_clk_i);
        power_event_i = 1'b0;
        save_trig_i = 1'b0;
    endtask
    task automatic test_reset();
        do_reset();
        `CHK("status", sas_pkg::STATUS_RESET, status_o)
        `CHK("devhead", sas_pkg::DEV_HEAD_OUT, dev_head_o)
        `CHK("loaded en", 1'b0, autosave_en_o)
        `CHK("ready", 1'b1, cmd_ready_o)
        end_test("reset");
    endtask
    task automatic test_unsup();
        h.issue(8'hD9, 8'h00, sas_pkg::CMD_SMART, lat);
        `CHK("unsup lat", 0, lat)
        `CHK("unsup status", sas_pkg::STATUS_ABORT, status_o)
        end_test("unsupported");
    endtask
    task automatic test_autosave();
        logic [7:0] sc [3] = '{8'hF1, 8'h37, 8'h00};
        logic en [3] = '{1'b1, 1'b1, 1'b0};
        for (int i = 0; i < 3; i++) begin
            h.issue(sas_pkg::FEAT_AUTOSAVE, sc[i], sas_pkg::CMD_SMART, lat);
            `CHK("as done", 1'b1, lat < 20)
            `CHK("as status", sas_pkg::STATUS_OK, status_o)
            `CHK("as devhead", sas_pkg::DEV_HEAD_OUT, dev_head_o)
            `CHK("as bytes", 0, h.nbytes)
            `CHK("as enable", en[i], autosave_en_o)
            `CHK("as stored", en[i], nv_store)
        end
        end_test("autosave");
    endtask
    task automatic test_idle_saves();
        int s0;
        s0 = saves;
        pulse_trig(1'b0);
        `CHK("trig off req", 1'b0, nv_req_o)
        repeat (4) @(negedge ref_clk_i);
        `CHK("trig off saves", s0, saves)
        pulse_trig(1'b1);
        `CHK("power req", 1'b1, nv_req_o)
        `CHK("power kind", 1'b0, nv_kind_flag_o)
        repeat (6) @(negedge ref_clk_i);
        `CHK("power saves", s0 + 1, saves)
        end_test("idle saves");
    endtask
    task automatic test_read(input logic [7:0] t, input int a, input int b,
                             input int avg, input logic mlc);
        int bad, life;
        logic [7:0] tv;
        temp_raw_i = t;
        bb_max_i = 16'(a);
        bb_cur_i = 16'(b);
        erase_avg_i = 16'(avg);
        mlc_i = mlc;
        tv = 8'(100 - h.temp_c(t));
        bad = (b >= a) ? 1 : 100 * (a - b) / a;
        if (bad < 1) bad = 1;
        life = 100 - 100 * avg / int'(mlc ? sas_pkg::ERASE_MAX_MLC :
                                           sas_pkg::ERASE_MAX_SLC);
        h.issue(sas_pkg::FEAT_READ_ATTR, 8'h01, sas_pkg::CMD_SMART, lat);
        `CHK("rd done", 1'b1, lat < 2000)
        `CHK("rd bytes", 512, h.nbytes)
        `CHK("rd status", sas_pkg::STATUS_OK, status_o)
        `CHK("temp id", sas_pkg::ID_TEMP, h.mem[2])
        `CHK("temp flag", sas_pkg::FLAG_TEMP, h.mem[3])
        `CHK("temp value", tv, h.mem[5])
        `CHK("temp raw", t, h.mem[7])
        `CHK("bb id", sas_pkg::ID_BAD_BLOCK, h.mem[14])
        `CHK("bb value", 8'(bad), h.mem[17])
        `CHK("life id", sas_pkg::ID_LIFE, h.mem[26])
        `CHK("life value", 8'(life), h.mem[29])
        `CHK("life raw", 8'(life), h.mem[31])
        `CHK("last byte", 8'h00, h.mem[511])
        end_test("read attribute");
    endtask
    task automatic test_save_latency();
        int a0;
        a0 = aborts;
        nv_hold = 1'b1;
        pulse_trig(1'b1);
        h.issue(sas_pkg::FEAT_AUTOSAVE, sas_pkg::SC_ENABLE,
                sas_pkg::CMD_SMART, lat);
        `CHK("late start", 1'b1, lat <= WL + 8)
        `CHK("abort", a0 + 1, aborts)
        `CHK("late en", 1'b1, autosave_en_o)
        `CHK("late store", 1'b1, nv_store)
        end_test("save latency");
    endtask
    task automatic test_trig_on();
        int s0;
        s0 = saves;
        pulse_trig(1'b0);
        `CHK("trig on req", 1'b1, nv_req_o)
        `CHK("trig on kind", 1'b0, nv_kind_flag_o)
        repeat (6) @(negedge ref_clk_i);
        `CHK("trig on saves", s0 + 1, saves)
        end_test("trigger enabled");
    endtask
    task automatic test_persist();
        do_reset();
        `CHK("kept en", 1'b1, autosave_en_o)
        end_test("persist");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(25ns * 30000);
        fails++;
        tally_and_finish();
    end
    initial begin
        test_reset();
        test_unsup();
        test_autosave();
        test_idle_saves();
        test_read(8'h1E, 10, 3, 15000, 1'b0);
        test_read(8'h80, 5, 7, 1500, 1'b1);
        // no bad blocks and no wear: both values at full scale
        test_read(8'h7F, 4, 0, 0, 1'b1);
        test_save_latency();
        test_trig_on();
        test_persist();
        tally_and_finish();
    end
endmodule // smart_attribute_autosave_tb
